// ==== logic/turn_on_fault_and_soft_off_timing.sv ====
// turn-on timeout fault reaction and soft-off timing sequencer
// assumes a decoded command port (code, data, strobes) from the bus engine
// and turn-on delay, rise time and timeout limit supplied from outside
`timescale 1ns/1ps
module turn_on_fault_and_soft_off_timing #(
	parameter int QMS_CYCLES     = seq_pkg::QMS_CYCLES,
	parameter int OFF_LAT_CYCLES = seq_pkg::OFF_LAT_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// decoded command port
	input  wire logic        cmd_wr,
	input  wire logic        cmd_rd,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [15:0] cmd_wdata,
	output logic      [15:0] cmd_rdata_q,
	output logic             cmd_rvalid_q,
	// converter control inputs
	input  wire logic        run_enable,
	input  wire logic        ton_delay_done,
	input  wire logic        vout_above_85pct,
	input  wire logic [7:0]  timeout_limit_hms,
	input  wire logic [6:0]  rise_time_qms,
	// status
	input  wire logic        status_clear,
	output logic             none_above_q,
	output logic             vout_summary_q,
	output logic             ton_timeout_q,
	output logic             invalid_data_q,
	output logic             alert_n_q,
	// power stage and reference
	output logic             power_on_q,
	output logic      [6:0]  ref_remaining_q,
	output logic      [6:0]  ref_span_q,
	output logic      [8:0]  state_q
);

	// ----------------------------------------------------------------
	// linear format to quarter milliseconds
	// ----------------------------------------------------------------
	function automatic logic [16:0] lin_qms(input logic [15:0] w);
		logic signed [5:0] sh;
		logic [16:0]       man;
		sh  = 6'(signed'(w[15:11])) + 6'sd2;
		man = {6'h00, w[10:0]};
		if (w[10])
			lin_qms = seq_pkg::LIN_INVALID;
		else if (sh >= 0) begin
			if (sh > 6 && man != 17'h00000)
				lin_qms = seq_pkg::LIN_INVALID;
			else
				lin_qms = man << sh;
		end else
			lin_qms = man >> (-sh);
	endfunction

	// ----------------------------------------------------------------
	// registers and decode
	// ----------------------------------------------------------------
	logic [7:0]  action_q;
	logic [15:0] off_delay_q;
	logic [15:0] fall_time_q;

	logic [1:0]  timeout_action_select;
	logic [2:0]  timeout_restart_count;
	logic [2:0]  timeout_shutdown_delay_code;
	logic [4:0]  off_delay_exponent;
	logic [10:0] off_delay_mantissa;
	logic [4:0]  fall_time_exponent;
	logic [10:0] fall_time_mantissa;

	assign timeout_action_select       = action_q[seq_pkg::ACT_SEL_LSB +: 2];
	assign timeout_restart_count       = action_q[seq_pkg::ACT_RETRY_LSB +: 3];
	assign timeout_shutdown_delay_code = action_q[seq_pkg::ACT_DELAY_LSB +: 3];
	assign off_delay_exponent          = off_delay_q[seq_pkg::LIN_EXP_LSB +: 5];
	assign off_delay_mantissa          = off_delay_q[10:0];
	assign fall_time_exponent          = fall_time_q[seq_pkg::LIN_EXP_LSB +: 5];
	assign fall_time_mantissa          = fall_time_q[10:0];

	logic        wr_action;
	logic        wr_delay;
	logic        wr_fall;
	logic [16:0] new_delay_qms;
	logic [16:0] new_fall_qms;
	logic        bad_action;
	logic        bad_delay;
	logic        bad_fall;
	logic        bad_write;

	assign wr_action     = cmd_wr && (cmd_code == seq_pkg::CMD_FAULT_ACTION);
	assign wr_delay      = cmd_wr && (cmd_code == seq_pkg::CMD_OFF_DELAY);
	assign wr_fall       = cmd_wr && (cmd_code == seq_pkg::CMD_FALL_TIME);
	assign new_delay_qms = lin_qms(cmd_wdata);
	assign new_fall_qms  = lin_qms(cmd_wdata);
	assign bad_action    = wr_action && (cmd_wdata[seq_pkg::ACT_SEL_LSB +: 2] == 2'h3);
	assign bad_delay     = wr_delay && (new_delay_qms > seq_pkg::OFF_DELAY_MAX_QMS);
	assign bad_fall      = wr_fall && (new_fall_qms > seq_pkg::FALL_MAX_QMS);
	assign bad_write     = bad_action || bad_delay || bad_fall;

	logic [16:0] delay_full;
	logic [8:0]  delay_qms;
	logic [16:0] fall_full;
	logic [6:0]  fall_raw;
	logic [6:0]  fall_qms;

	assign delay_full = lin_qms(off_delay_q);
	assign delay_qms  = {delay_full[8:1], 1'b0};
	assign fall_full  = lin_qms(fall_time_q);
	assign fall_raw   = fall_full[6:0];
	assign fall_qms   = (fall_raw < seq_pkg::FALL_MIN_QMS) ? seq_pkg::FALL_MIN_QMS : fall_raw;

	logic [9:0]  fdly_qms;
	logic [2:0]  hic_mult;
	logic [6:0]  rise_eff;
	logic [9:0]  hiccup_qms;

	assign fdly_qms   = (timeout_shutdown_delay_code == 3'h0) ? 10'(seq_pkg::QMS_PER_MS)
		: 10'(timeout_shutdown_delay_code) * 10'(seq_pkg::QMS_PER_MS);
	assign hic_mult   = (timeout_shutdown_delay_code < 3'h2) ? timeout_shutdown_delay_code + 3'h1
		: timeout_shutdown_delay_code;
	assign rise_eff   = (rise_time_qms < seq_pkg::FALL_MIN_QMS) ? seq_pkg::FALL_MIN_QMS : rise_time_qms;
	assign hiccup_qms = 10'(rise_eff) * 10'(hic_mult);

	// ----------------------------------------------------------------
	// timebase
	// ----------------------------------------------------------------
	tick_if tk ();

	qms_divider #(
		.CYCLES (QMS_CYCLES)
	) u_div (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tk      (tk.gen)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	seq_pkg::seq_state_e st_q;
	seq_pkg::seq_state_e st_d;
	logic [9:0]  tick_cnt_q;
	logic [15:0] cyc_cnt_q;
	logic [2:0]  tries_left_q;
	logic [2:0]  tries_left_d;
	logic        fault_evt;
	logic        limit_hit;
	logic        fdly_done;
	logic        hiccup_done;
	logic        lat_done;
	logic        odly_done;
	logic        fall_done;
	logic        can_retry;
	seq_pkg::seq_state_e shut_st;

	// limit counted from turn-on delay end
	assign limit_hit   = (timeout_limit_hms != 8'h00) && (tick_cnt_q >= {1'b0, timeout_limit_hms, 1'b0});
	assign fault_evt   = (st_q == seq_pkg::ST_START) && run_enable && !vout_above_85pct && limit_hit;
	assign fdly_done   = tick_cnt_q >= fdly_qms;
	assign hiccup_done = tick_cnt_q >= hiccup_qms;
	// fixed latency ahead of the delay
	assign lat_done    = cyc_cnt_q >= 16'(OFF_LAT_CYCLES - 1);
	assign odly_done   = tick_cnt_q >= {1'b0, delay_qms};
	assign fall_done   = tick_cnt_q >= {3'h0, ref_span_q};
	assign can_retry   = (timeout_restart_count == seq_pkg::RETRY_FOREVER) || (tries_left_q != 3'h0);
	assign shut_st     = (timeout_restart_count == seq_pkg::RETRY_LATCH || !can_retry)
		? seq_pkg::ST_LATCHED : seq_pkg::ST_HICCUP;

	always_comb begin
		st_d         = st_q;
		tries_left_d = tries_left_q;
		case (st_q)
			seq_pkg::ST_OFF: begin
				if (run_enable && ton_delay_done) begin
					st_d         = seq_pkg::ST_START;
					tries_left_d = timeout_restart_count;
				end
			end
			seq_pkg::ST_START: begin
				if (!run_enable)
					st_d = seq_pkg::ST_OFF_LAT;
				else if (vout_above_85pct)
					st_d = seq_pkg::ST_RUN;
				else if (fault_evt) begin
					case (timeout_action_select)
						seq_pkg::SEL_IGNORE:  st_d = seq_pkg::ST_RUN;
						seq_pkg::SEL_DELAYED: st_d = seq_pkg::ST_FLT_DLY;
						default:              st_d = shut_st;
					endcase
				end
			end
			seq_pkg::ST_RUN: begin
				if (!run_enable)
					st_d = seq_pkg::ST_OFF_LAT;
			end
			seq_pkg::ST_FLT_DLY: begin
				if (!run_enable)
					st_d = seq_pkg::ST_OFF_LAT;
				else if (vout_above_85pct)
					st_d = seq_pkg::ST_RUN;
				else if (fdly_done)
					st_d = shut_st;
			end
			seq_pkg::ST_HICCUP: begin
				if (!run_enable)
					st_d = seq_pkg::ST_OFF;
				else if (hiccup_done) begin
					st_d = seq_pkg::ST_START;
					if (timeout_restart_count != seq_pkg::RETRY_FOREVER)
						tries_left_d = tries_left_q - 3'h1;
				end
			end
			seq_pkg::ST_LATCHED: begin
				if (!run_enable)
					st_d = seq_pkg::ST_OFF;
			end
			seq_pkg::ST_OFF_LAT: begin
				if (lat_done)
					st_d = seq_pkg::ST_OFF_DLY;
			end
			seq_pkg::ST_OFF_DLY: begin
				if (odly_done)
					st_d = seq_pkg::ST_FALL;
			end
			seq_pkg::ST_FALL: begin
				if (fall_done)
					st_d = seq_pkg::ST_OFF;
			end
			default: st_d = seq_pkg::ST_OFF;
		endcase
	end

	// hold the divider in step with each state entry
	assign tk.restart = (st_d != st_q);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q         <= seq_pkg::ST_OFF;
			tries_left_q <= 3'h0;
		end else begin
			st_q         <= st_d;
			tries_left_q <= tries_left_d;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || tk.restart) begin
			tick_cnt_q <= 10'h000;
			cyc_cnt_q  <= 16'h0000;
		end else begin
			if (tk.tick && tick_cnt_q != 10'h3FF)
				tick_cnt_q <= tick_cnt_q + 10'h001;
			if (cyc_cnt_q != 16'hFFFF)
				cyc_cnt_q <= cyc_cnt_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// power stage and soft-off reference
	// ----------------------------------------------------------------
	logic       power_on_d;
	logic [6:0] remain_d;

	assign power_on_d = (st_d == seq_pkg::ST_START) || (st_d == seq_pkg::ST_RUN)
		|| (st_d == seq_pkg::ST_FLT_DLY) || (st_d == seq_pkg::ST_OFF_LAT)
		|| (st_d == seq_pkg::ST_OFF_DLY) || (st_d == seq_pkg::ST_FALL);
	// remaining fraction of span, voltage independent
	assign remain_d   = (st_d != seq_pkg::ST_FALL) ? fall_qms
		: (st_q != seq_pkg::ST_FALL) ? fall_qms
		: (tk.tick && ref_remaining_q != 7'h00) ? ref_remaining_q - 7'h01 : ref_remaining_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			power_on_q      <= 1'b0;
			ref_remaining_q <= 7'h00;
			ref_span_q      <= seq_pkg::FALL_MIN_QMS;
			state_q         <= 9'h001;
		end else begin
			power_on_q      <= power_on_d;
			ref_remaining_q <= remain_d;
			if (st_q != seq_pkg::ST_FALL)
				ref_span_q <= fall_qms;
			state_q         <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// command registers and readback
	// ----------------------------------------------------------------
	logic [15:0] rdata_d;

	assign rdata_d = (cmd_code == seq_pkg::CMD_FAULT_ACTION) ? {8'h00, action_q}
		: (cmd_code == seq_pkg::CMD_OFF_DELAY) ? off_delay_q
		: (cmd_code == seq_pkg::CMD_FALL_TIME) ? fall_time_q : 16'h0000;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			action_q     <= seq_pkg::ACTION_RST;
			off_delay_q  <= {seq_pkg::OFF_DELAY_EXP, seq_pkg::OFF_DELAY_MAN};
			fall_time_q  <= {seq_pkg::FALL_EXP, seq_pkg::FALL_MAN};
			cmd_rdata_q  <= 16'h0000;
			cmd_rvalid_q <= 1'b0;
		end else begin
			if (wr_action && !bad_action)
				action_q <= cmd_wdata[7:0];
			if (wr_delay && !bad_delay)
				off_delay_q <= cmd_wdata;
			if (wr_fall && !bad_fall)
				fall_time_q <= cmd_wdata;
			cmd_rvalid_q <= cmd_rd;
			if (cmd_rd)
				cmd_rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// status flags, set wins over clear except a repeat timeout fault while ton_timeout_q is already set
	// ----------------------------------------------------------------
	logic tmo_set;

	assign tmo_set = fault_evt && (st_d != st_q || timeout_action_select == seq_pkg::SEL_IGNORE)
		&& !ton_timeout_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			none_above_q   <= 1'b0;
			vout_summary_q <= 1'b0;
			ton_timeout_q  <= 1'b0;
			invalid_data_q <= 1'b0;
			alert_n_q      <= 1'b1;
		end else begin
			none_above_q   <= tmo_set || (none_above_q && !status_clear);
			vout_summary_q <= tmo_set || (vout_summary_q && !status_clear);
			ton_timeout_q  <= tmo_set || (ton_timeout_q && !status_clear);
			invalid_data_q <= bad_write || (invalid_data_q && !status_clear);
			alert_n_q      <= !(tmo_set || bad_write || ((ton_timeout_q || invalid_data_q) && !status_clear));
		end
	end

endmodule

// ==== logic/seq_pkg.sv ====
// constants for turn-on timeout fault handling and soft-off timing
// assumes a 250 MHz core clock and a decoded command port in front
// What this block does
// - timeout fault sets summary, word, vout bits, alerts
// - action 00b ignores fault, keeps converting
// - action 01b waits delay, then shuts down
// - action 10b shuts down immediately, then retries or latches off per restart count
// - bad action write flags invalid data
// - restart count 0 latches off
// - count 1-6 hiccups and retries that often
// - delay code 0: 1 ms, hiccup one rise
// - codes 1-7: 1-7 ms, hiccup 2-7 rises
// - stop condition waits off delay, then stops
// - off delay 0 to 127.5 ms, 0.5 ms
// - up to 50 us latency added on every stop from start, run or fault delay
// - after delay reference ramps down over fall
// - ramp length independent of output voltage
// - fall 0.5-31.75 ms, below 0.5 clamps
// - fall exponent resets to -2
// - off delay word linear, exponent resets -1
// - out-of-range delay or fall write flags invalid
// - fault when not 85 percent within limit
package seq_pkg;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_FAULT_ACTION = 8'h63;
	localparam logic [7:0] CMD_OFF_DELAY    = 8'h64;
	localparam logic [7:0] CMD_FALL_TIME    = 8'h65;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ACT_SEL_LSB   = 6;
	localparam int ACT_RETRY_LSB = 3;
	localparam int ACT_DELAY_LSB = 0;
	localparam int LIN_EXP_LSB   = 11;

	// ----------------------------------------------------------------
	// field encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_IGNORE    = 2'h0;
	localparam logic [1:0] SEL_DELAYED   = 2'h1;
	localparam logic [1:0] SEL_IMMEDIATE = 2'h2;
	localparam logic [2:0] RETRY_LATCH   = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  ACTION_RST     = 8'h80;
	localparam logic [4:0]  OFF_DELAY_EXP  = 5'h1F;
	localparam logic [4:0]  FALL_EXP       = 5'h1E;
	localparam logic [10:0] OFF_DELAY_MAN  = 11'h000;
	localparam logic [10:0] FALL_MAN       = 11'h004;

	// ----------------------------------------------------------------
	// limits in quarter-millisecond units
	// ----------------------------------------------------------------
	localparam logic [16:0] OFF_DELAY_MAX_QMS = 17'h001FE;
	localparam logic [16:0] FALL_MAX_QMS      = 17'h0007F;
	localparam logic [6:0]  FALL_MIN_QMS      = 7'h02;
	localparam logic [16:0] LIN_INVALID       = 17'h1FFFF;
	localparam int          QMS_PER_MS        = 4;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int QMS_TIME_PS    = 250000000;
	localparam int OFF_LAT_PS     = 50000000;
	localparam int QMS_CYCLES     = QMS_TIME_PS / CLK_PERIOD_PS;
	localparam int OFF_LAT_CYCLES = OFF_LAT_PS / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [8:0] {
		ST_OFF     = 9'h001,
		ST_START   = 9'h002,
		ST_RUN     = 9'h004,
		ST_FLT_DLY = 9'h008,
		ST_HICCUP  = 9'h010,
		ST_LATCHED = 9'h020,
		ST_OFF_LAT = 9'h040,
		ST_OFF_DLY = 9'h080,
		ST_FALL    = 9'h100
	} seq_state_e;

endpackage

// ==== logic/tick_if.sv ====
// carrier between the sequencer and its millisecond-fraction timebase
// assumes both ends share the core clock
`timescale 1ns/1ps
interface tick_if;
	logic restart;
	logic tick;

	modport gen (
		input  restart,
		output tick
	);
	modport use_tick (
		output restart,
		input  tick
	);
endinterface

// ==== logic/qms_divider.sv ====
// quarter-millisecond enable divider
// assumes a synchronous active-high reset and one core clock
`timescale 1ns/1ps
module qms_divider #(
	parameter int CYCLES = seq_pkg::QMS_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// tick carrier
	tick_if.gen      tk
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic        wrap;
	logic        tick_q;

	assign wrap  = (cnt_q == 32'(CYCLES - 1));
	assign cnt_d = (tk.restart || wrap) ? 32'h00000000 : cnt_q + 32'h00000001;
	assign tk.tick = tick_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q  <= 32'h00000000;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= wrap && !tk.restart;
		end
	end
endmodule

// ==== tb/host_cmd_model.sv ====
// host side model driving the decoded command port
// assumes the design samples requests on the rising clock edge
`timescale 1ns/1ps
module host_cmd_model (
	// clock
	input  wire logic        clk,
	// command port
	output logic             cmd_wr,
	output logic             cmd_rd,
	output logic      [7:0]  cmd_code,
	output logic      [15:0] cmd_wdata,
	input  wire logic [15:0] cmd_rdata_q,
	input  wire logic        cmd_rvalid_q
);
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	task automatic write_cmd(input logic [7:0] code, input logic [15:0] data);
		@(negedge clk);
		cmd_wr = 1'b1;
		cmd_code = code;
		cmd_wdata = data;
		@(negedge clk);
		cmd_wr = 1'b0;
		// released lines must not keep the last value
		cmd_code = ~code;
		cmd_wdata = ~data;
	endtask
	task automatic read_cmd(input logic [7:0] code, output logic [15:0] data);
		int k;
		k = 0;
		@(negedge clk);
		cmd_rd = 1'b1;
		cmd_code = code;
		@(negedge clk);
		cmd_rd = 1'b0;
		cmd_code = ~code;
		while (cmd_rvalid_q !== 1'b1 && k < 4) begin
			@(negedge clk);
			k++;
		end
		data = cmd_rdata_q;
	endtask
endmodule

// ==== tb/seq_checker.sv ====
// assertions on the sequencer top ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module seq_checker #(
	parameter int OFF_LAT_CYCLES = 4
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// controls
	input wire logic       run_enable,
	input wire logic       ton_delay_done,
	// watched outputs
	input wire logic       none_above_q,
	input wire logic       vout_summary_q,
	input wire logic       ton_timeout_q,
	input wire logic       alert_n_q,
	input wire logic       power_on_q,
	input wire logic [6:0] ref_remaining_q,
	input wire logic [6:0] ref_span_q,
	input wire logic [8:0] state_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// ----
	// latency counter
	// ----
	logic [15:0] lat_cnt_q;
	logic [15:0] lat_cnt_d;
	wire logic   in_lat;
	wire logic   in_fall;
	assign in_lat = state_q == seq_pkg::ST_OFF_LAT;
	assign in_fall = state_q == seq_pkg::ST_FALL;
	assign lat_cnt_d = in_lat ? lat_cnt_q + 16'h0001 : 16'h0000;
	always_ff @(posedge clk) begin
		lat_cnt_q <= sys_rst ? 16'h0000 : lat_cnt_d;
	end
	// ----
	// properties
	// ----
	property p_fault_flags;
		$rose(ton_timeout_q) |-> none_above_q && vout_summary_q && !alert_n_q;
	endproperty
	a_fault_flags: assert property (p_fault_flags) else $error("fault flags incomplete");
	property p_start;
		state_q == seq_pkg::ST_OFF && run_enable && ton_delay_done |=> state_q == seq_pkg::ST_START && power_on_q;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_latched;
		state_q == seq_pkg::ST_LATCHED && run_enable |=> state_q == seq_pkg::ST_LATCHED && !power_on_q;
	endproperty
	a_latched: assert property (p_latched) else $error("latch left");
	property p_hiccup;
		state_q == seq_pkg::ST_HICCUP |-> !power_on_q;
	endproperty
	a_hiccup: assert property (p_hiccup) else $error("powered in hiccup");
	property p_stop;
		state_q == seq_pkg::ST_RUN && !run_enable |-> ##[1:2] in_lat;
	endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_latency;
		in_lat ##1 !in_lat |-> lat_cnt_q >= OFF_LAT_CYCLES - 1 && lat_cnt_q <= OFF_LAT_CYCLES + 1;
	endproperty
	a_latency: assert property (p_latency) else $error("latency length wrong");
	property p_ramp;
		in_fall ##1 in_fall |-> $stable(ref_span_q) && ref_remaining_q <= $past(ref_remaining_q) && power_on_q;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp not falling");
	property p_span_min;
		ref_span_q >= 7'h02;
	endproperty
	a_span_min: assert property (p_span_min) else $error("fall span below minimum");
	c_fall: cover property (in_fall ##1 state_q == seq_pkg::ST_OFF);
	c_hiccup: cover property (state_q == seq_pkg::ST_HICCUP);
	c_latched: cover property (state_q == seq_pkg::ST_LATCHED);
endmodule
bind turn_on_fault_and_soft_off_timing seq_checker #(.OFF_LAT_CYCLES(OFF_LAT_CYCLES)) seq_checker_i (
	.clk(clk), .sys_rst(sys_rst), .run_enable(run_enable), .ton_delay_done(ton_delay_done),
	.none_above_q(none_above_q), .vout_summary_q(vout_summary_q), .ton_timeout_q(ton_timeout_q),
	.alert_n_q(alert_n_q), .power_on_q(power_on_q), .ref_remaining_q(ref_remaining_q),
	.ref_span_q(ref_span_q), .state_q(state_q)
);

// ==== tb/turn_on_fault_and_soft_off_timing_tb.sv ====
// self-checking bench for the turn-on fault and soft-off sequencer
// assumes shortened tick and latency counts set below
`timescale 1ns/1ps
module turn_on_fault_and_soft_off_timing_tb;
	localparam int QMS = 8;
	localparam int LAT = 4;
	typedef struct packed {
		logic [7:0]  code;
		logic [15:0] wdata;
		logic        inv;
		logic [15:0] rd;
	} row_s;
	// code, write data, rejected, read back
	row_s rows [7] = '{
		'{8'h63, 16'h00C0, 1'b1, 16'h0080},
		'{8'h63, 16'h0041, 1'b0, 16'h0041},
		'{8'h64, 16'hF8FF, 1'b0, 16'hF8FF},
		'{8'h64, 16'hF900, 1'b1, 16'hF8FF},
		'{8'h64, 16'hFFFF, 1'b1, 16'hF8FF},
		'{8'h65, 16'hF07F, 1'b0, 16'hF07F},
		'{8'h65, 16'hF080, 1'b1, 16'hF07F}
	};
	logic        clk;
	logic        sys_rst;
	logic        cmd_wr;
	logic        cmd_rd;
	logic [7:0]  cmd_code;
	logic [15:0] cmd_wdata;
	logic [15:0] cmd_rdata_q;
	logic        cmd_rvalid_q;
	logic        run_enable;
	logic        ton_delay_done;
	logic        vout_above_85pct;
	logic        status_clear;
	logic [7:0]  limit_hms;
	logic        none_above_q;
	logic        vout_summary_q;
	logic        ton_timeout_q;
	logic        invalid_data_q;
	logic        alert_n_q;
	logic        power_on_q;
	logic [6:0]  ref_remaining_q;
	logic [6:0]  ref_span_q;
	logic [8:0]  state_q;
	logic [15:0] rdv;
	logic [6:0]  span;
	logic        pw_prev;
	int          miscompares;
	int          num_checks;
	int          cyc;
	int          rises;
	int          n;
	turn_on_fault_and_soft_off_timing #(.QMS_CYCLES(QMS), .OFF_LAT_CYCLES(LAT)) turn_on_fault_and_soft_off_timing_i (
		.clk(clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .cmd_rdata_q(cmd_rdata_q), .cmd_rvalid_q(cmd_rvalid_q),
		.run_enable(run_enable), .ton_delay_done(ton_delay_done), .vout_above_85pct(vout_above_85pct),
		.timeout_limit_hms(limit_hms), .rise_time_qms(7'h02), .status_clear(status_clear),
		.none_above_q(none_above_q), .vout_summary_q(vout_summary_q), .ton_timeout_q(ton_timeout_q),
		.invalid_data_q(invalid_data_q), .alert_n_q(alert_n_q), .power_on_q(power_on_q),
		.ref_remaining_q(ref_remaining_q), .ref_span_q(ref_span_q), .state_q(state_q)
	);
	host_cmd_model host_cmd_model_i (
		.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.cmd_rdata_q(cmd_rdata_q), .cmd_rvalid_q(cmd_rvalid_q)
	);
	always #2 clk = ~clk;
	// power-up counter
	always @(negedge clk) begin
		pw_prev <= power_on_q;
		if (power_on_q === 1'b1 && pw_prev === 1'b0) begin
			rises <= rises + 1;
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_range(input int got, input int lo, input int hi);
		num_checks++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic check_st(input logic [8:0] s);
		check_eq(16'(state_q), 16'(s));
	endtask
	task automatic wait_state(input logic [8:0] s, input int lim);
		n = 0;
		while (state_q !== s && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic start_up();
		run_enable = 1'b1;
		@(negedge clk);
		ton_delay_done = 1'b1;
		@(negedge clk);
		ton_delay_done = 1'b0;
	endtask
	task automatic stop_to_off();
		run_enable = 1'b0;
		wait_state(seq_pkg::ST_OFF, 80);
		check_st(seq_pkg::ST_OFF);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		run_enable = 1'b0;
		ton_delay_done = 1'b0;
		vout_above_85pct = 1'b0;
		status_clear = 1'b0;
		miscompares = 0;
		num_checks = 0;
		cyc = 0;
		limit_hms = 8'h01;
		rises = 0;
		pw_prev = 1'b0;
		span = 7'h00;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		foreach (rows[i]) begin
			status_clear = 1'b1;
			@(negedge clk);
			status_clear = 1'b0;
			host_cmd_model_i.write_cmd(rows[i].code, rows[i].wdata);
			check_eq(16'(invalid_data_q), 16'(rows[i].inv));
			host_cmd_model_i.read_cmd(rows[i].code, rdv);
			check_eq(rdv, rows[i].rd);
		end
		$display("test register table done");
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		host_cmd_model_i.read_cmd(8'h64, rdv);
		check_eq(rdv, 16'hF800);
		host_cmd_model_i.read_cmd(8'h65, rdv);
		check_eq(rdv, 16'hF004);
		check_eq({12'h000, ton_timeout_q, invalid_data_q, alert_n_q, power_on_q}, 16'h0002);
		$display("test reset done");
		host_cmd_model_i.write_cmd(8'h63, 16'h0000);
		start_up();
		wait_state(seq_pkg::ST_RUN, 40);
		check_range(n, 2 * QMS - 2, 2 * QMS + 4);
		check_eq({12'h000, ton_timeout_q, none_above_q, vout_summary_q, alert_n_q}, 16'h000E);
		check_eq(16'(power_on_q), 16'h0001);
		$display("test ignore done");
		vout_above_85pct = 1'b1;
		host_cmd_model_i.write_cmd(8'h65, 16'hF001);
		host_cmd_model_i.write_cmd(8'h64, 16'hF801);
		run_enable = 1'b0;
		n = 0;
		while (power_on_q === 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
			if (state_q === seq_pkg::ST_FALL) begin
				span = ref_span_q;
				rdv = 16'(ref_remaining_q);
			end
		end
		check_range(n, LAT + 4 * QMS, LAT + 4 * QMS + 6);
		check_eq(16'(span), 16'h0002);
		check_eq(rdv, 16'h0000);
		check_st(seq_pkg::ST_OFF);
		$display("test soft off done");
		vout_above_85pct = 1'b0;
		host_cmd_model_i.write_cmd(8'h63, 16'h0080);
		start_up();
		wait_state(seq_pkg::ST_LATCHED, 40);
		check_range(n, 2 * QMS - 2, 2 * QMS + 4);
		start_up();
		repeat (4) @(negedge clk);
		check_st(seq_pkg::ST_LATCHED);
		stop_to_off();
		$display("test latch done");
		host_cmd_model_i.write_cmd(8'h63, 16'h0091);
		rises = 0;
		start_up();
		wait_state(seq_pkg::ST_LATCHED, 400);
		check_range(n, 14 * QMS, 14 * QMS + 14);
		check_range(rises, 3, 3);
		stop_to_off();
		$display("test limited retry done");
		host_cmd_model_i.write_cmd(8'h63, 16'h0040);
		start_up();
		wait_state(seq_pkg::ST_FLT_DLY, 40);
		check_eq(16'(power_on_q), 16'h0001);
		wait_state(seq_pkg::ST_LATCHED, 60);
		check_range(n, 4 * QMS - 2, 4 * QMS + 3);
		stop_to_off();
		$display("test delayed done");
		host_cmd_model_i.write_cmd(8'h63, 16'h00B8);
		rises = 0;
		start_up();
		repeat (300) @(negedge clk);
		check_range(rises, 8, 11);
		stop_to_off();
		$display("test endless retry done");
		limit_hms = 8'h00;
		start_up();
		repeat (40) @(negedge clk);
		check_st(seq_pkg::ST_START);
		stop_to_off();
		$display("test no limit done");
		tally_and_finish();
	end
endmodule
